// ===== hw/dcp_channel.sv
// DMA channel with cell sizing, cell progress tracking and pattern terminate
//
// Overview of operation
// RULE1: Each transfer event moves cell-size bytes; a size of zero means 65,536.
// RULE2: Read-only 16-bit progress count shows bytes moved since last transfer event.
// RULE3: In pattern mode, progress count clears to zero when the pattern is seen.
// RULE4: In pattern terminate mode, a moved byte equal to pattern byte ends transfer.
// RULE5: Outside pattern terminate mode the pattern byte does nothing but stays read/write.
// RULE6: Cell size and progress registers read zero in bits 31-16.
// RULE7: Pattern register reads zero in bits 31-8.
// RULE8: Progress rises by one per moved byte, returns to zero after a whole cell.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "dcp_regs.svh"

module dcp_channel #(
	parameter int ADDR_W     = 8,
	parameter int FIFO_DEPTH = `DCP_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wrData,
	input  wire logic              wrStrobe,
	input  wire logic              rdStrobe,
	output logic [31:0]            rdData,
	// Transfer event from a peripheral
	input  wire logic              startEvent,
	// Source byte stream
	input  wire logic              srcValid,
	input  wire logic [7:0]        srcData,
	output logic                   srcReady,
	// Destination byte stream
	output logic                   dstValid,
	output logic [7:0]             dstData,
	input  wire logic              dstReady,
	// Channel status
	output logic                   busy,
	output logic                   cellDone,
	output logic                   patternEnd
);

	// Refuse an address port too narrow for the register map
	if (ADDR_W < 5) begin : gBadAddr
		$error("dcp_channel: ADDR_W must be at least 5");
	end

	// The buffer wraps its pointers, so only a power-of-two depth works
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : gBadDepth
		$error("dcp_channel: FIFO_DEPTH must be a power of two of at least 2");
	end

	dcp_pkg::dcp_chan_t q_reg;
	dcp_pkg::dcp_chan_t q_next;

	// Places of the registers in the select vectors
	localparam int NUM_REGS = 5;
	localparam int SEL_SIZE = 0;
	localparam int SEL_PROG = 1;
	localparam int SEL_PAT  = 2;
	localparam int SEL_CTRL = 3;
	localparam int SEL_STAT = 4;

	logic        acceptByte;
	logic        patternHit;
	logic        fifoInReady;
	logic [16:0] progressInc;
	logic [3:0]  statusView;
	logic [3:0]  stickyClr;
	logic [3:0]  stickySet;
	logic [3:0]  stickyNow;
	logic        doneEvt;
	logic        hitEvt;
	logic        ovrEvt;
	logic [31:0] controlWord;
	logic [31:0] readWord;
	logic [NUM_REGS-1:0] regSel;
	logic [NUM_REGS-1:0] wrSel;
	logic [NUM_REGS-1:0] rdSel;

	// Compare the whole address port against a register offset sized to the port
	function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		addrIs = (a == ADDR_W'(off));
	endfunction : addrIs

	// Length of one cell from the size field
	function automatic logic [16:0] cellLength(input logic [15:0] size);
		if (size == 16'h0000) begin
			cellLength = `DCP_CELL_LEN_ZERO; // see RULE1
		end else begin
			cellLength = {1'b0, size}; // see RULE1
		end
	endfunction : cellLength

	// Byte offset of each register, indexed by its place in the select vectors
	function automatic logic [7:0] regOffset(input int idx);
		case (idx)
			SEL_SIZE: regOffset = `DCP_OFF_CELL_SIZE;
			SEL_PROG: regOffset = `DCP_OFF_CELL_PROGRESS;
			SEL_PAT:  regOffset = `DCP_OFF_MATCH_PATTERN;
			SEL_CTRL: regOffset = `DCP_OFF_CONTROL;
			SEL_STAT: regOffset = `DCP_OFF_STATUS;
			default:  regOffset = 8'hff; // Never used; points outside the map
		endcase
	endfunction : regOffset

	// Sticky bit update; a set in the same cycle as a clear wins, so no event is lost
	function automatic logic stickyBit(input logic held, input logic clr, input logic setNow);
		stickyBit = (held & ~clr) | setNow;
	endfunction : stickyBit

	// One select bit per register; an unmapped address selects nothing
	for (genvar r = 0; r < NUM_REGS; r++) begin : gDecode
		assign regSel[r] = addrIs(addr, regOffset(r));
	end

	// Strobes qualify the selects; the master never raises both at once
	assign wrSel = wrStrobe ? regSel : '0;
	assign rdSel = rdStrobe ? regSel : '0;

	// A byte moves when the source offers it and the channel can take it
	assign srcReady   = (q_reg.state == dcp_pkg::DCP_MOVE) & q_reg.enable & fifoInReady;
	assign acceptByte = srcValid & srcReady;

	// Pattern only reaches the logic through the terminate-mode gate
	dcp_pattern_cmp uCmp (
		.termMode    (q_reg.patTerm), // see RULE5
		.byteValid   (acceptByte),
		.byteData    (srcData),
		.patternByte (q_reg.pattern),
		.hit         (patternHit)
	);

	// Moved bytes pass through the buffer; a slow destination stalls the source
	dcp_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.clock    (clock),
		.rst_n    (rst_n),
		.inValid  (acceptByte),
		.inData   (srcData),
		.inReady  (fifoInReady),
		.outValid (dstValid),
		.outData  (dstData),
		.outReady (dstReady)
	);

	assign progressInc = {1'b0, q_reg.progress} + 17'h00001;

	// Events of this cycle; a pattern hit outranks the end of the cell
	assign hitEvt  = acceptByte & patternHit; // see RULE4
	assign doneEvt = acceptByte & ~patternHit & (progressInc == q_reg.cellLen); // see RULE1
	assign ovrEvt  = startEvent & (q_reg.state == dcp_pkg::DCP_MOVE);

	// Control register as software sees it, unused bits zero
	always_comb begin
		controlWord                       = 32'h0000_0000;
		controlWord[`DCP_CTRL_ENABLE_BIT] = q_reg.enable;
		controlWord[`DCP_CTRL_PTERM_BIT]  = q_reg.patTerm;
	end

	// Read multiplexer; unimplemented upper bits are tied to zero
	always_comb begin
		readWord = 32'h0000_0000;
		if (rdSel[SEL_SIZE]) begin
			readWord = {16'h0000, q_reg.cellSize}; // see RULE6
		end
		if (rdSel[SEL_PROG]) begin
			readWord = {16'h0000, q_reg.progress}; // see RULE2, RULE6
		end
		if (rdSel[SEL_PAT]) begin
			readWord = {24'h000000, q_reg.pattern}; // see RULE7
		end
		if (rdSel[SEL_CTRL]) begin
			readWord = controlWord;
		end
		if (rdSel[SEL_STAT]) begin
			readWord = {28'h0000000, statusView};
		end
	end

	// Live view of the status bits, busy included
	assign statusView = {q_reg.ovrFlag, q_reg.hitFlag, q_reg.doneFlag,
	                     q_reg.state == dcp_pkg::DCP_MOVE};

	// Write-one-to-clear mask for the sticky status bits
	assign stickyClr = wrSel[SEL_STAT] ? wrData[3:0] : 4'h0;

	// Events that set the sticky bits; fed from events so no loop forms through q_next
	always_comb begin
		stickySet = 4'h0;
		stickySet[`DCP_STAT_DONE_BIT] = doneEvt;
		stickySet[`DCP_STAT_HIT_BIT]  = hitEvt;
		stickySet[`DCP_STAT_OVR_BIT]  = ovrEvt;
	end

	// Sticky status bits; the busy bit is live and never stored
	for (genvar i = 0; i < 4; i++) begin : gSticky
		if (i >= `DCP_STAT_STICKY_LO && i <= `DCP_STAT_STICKY_HI) begin : gBit
			assign stickyNow[i] = stickyBit(statusView[i], stickyClr[i], stickySet[i]);
		end else begin : gLive
			assign stickyNow[i] = 1'b0;
		end
	end

	// Next state of the whole channel
	always_comb begin
		q_next       = q_reg;
		q_next.doneP = 1'b0;
		q_next.hitP  = 1'b0;

		// Register writes; a new size only counts from the next event
		if (wrSel[SEL_SIZE]) begin
			q_next.cellSize = wrData[15:0];
		end
		// Pattern stays writable in every mode
		if (wrSel[SEL_PAT]) begin
			q_next.pattern = wrData[7:0]; // see RULE5
		end
		// Clearing enable mid-cell aborts the cell
		if (wrSel[SEL_CTRL]) begin
			q_next.enable  = wrData[`DCP_CTRL_ENABLE_BIT];
			q_next.patTerm = wrData[`DCP_CTRL_PTERM_BIT];
		end

		// Sequencer
		case (q_reg.state)
			dcp_pkg::DCP_IDLE: begin
				// Events are ignored while the channel is switched off
				if (startEvent && q_reg.enable) begin
					q_next.cellLen  = cellLength(q_reg.cellSize); // see RULE1
					q_next.progress = `DCP_RST_PROGRESS; // see RULE2
					q_next.state    = dcp_pkg::DCP_MOVE;
				end
			end
			dcp_pkg::DCP_MOVE: begin
				if (!q_reg.enable) begin
					// Software switched off mid-cell; progress is kept for inspection
					q_next.state = dcp_pkg::DCP_IDLE;
				end else if (acceptByte) begin
					if (patternHit) begin
						q_next.progress = `DCP_RST_PROGRESS; // see RULE3
						q_next.hitP     = 1'b1; // see RULE4
						q_next.state    = dcp_pkg::DCP_IDLE; // see RULE4
					end else if (progressInc == q_reg.cellLen) begin
						q_next.progress = `DCP_RST_PROGRESS; // see RULE8
						q_next.doneP    = 1'b1; // see RULE1
						q_next.state    = dcp_pkg::DCP_IDLE;
					end else begin
						q_next.progress = progressInc[15:0]; // see RULE8
					end
				end
			end
			default: begin
				q_next.state = dcp_pkg::DCP_IDLE;
			end
		endcase

		// Sticky flags take the computed value
		q_next.doneFlag = stickyNow[`DCP_STAT_DONE_BIT];
		q_next.hitFlag  = stickyNow[`DCP_STAT_HIT_BIT];
		q_next.ovrFlag  = stickyNow[`DCP_STAT_OVR_BIT];

		// Read data holds only in the cycle after the strobe
		q_next.rdData = readWord;
	end

	// Single state register, synchronous reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			q_reg.state    <= dcp_pkg::DCP_IDLE;
			q_reg.enable   <= 1'b0;
			q_reg.patTerm  <= 1'b0;
			q_reg.cellLen  <= 17'h00000;
			q_reg.doneFlag <= 1'b0;
			q_reg.hitFlag  <= 1'b0;
			q_reg.ovrFlag  <= 1'b0;
			q_reg.doneP    <= 1'b0;
			q_reg.hitP     <= 1'b0;
			q_reg.rdData   <= 32'h0000_0000;
			q_reg.cellSize <= `DCP_RST_CELL_SIZE;
			q_reg.pattern  <= `DCP_RST_PATTERN;
			q_reg.progress <= `DCP_RST_PROGRESS;
		end else begin
			q_reg <= q_next;
		end
	end

	// Outputs straight from the state register
	assign rdData     = q_reg.rdData;
	assign busy       = (q_reg.state == dcp_pkg::DCP_MOVE);
	assign cellDone   = q_reg.doneP;
	assign patternEnd = q_reg.hitP;

endmodule : dcp_channel

// ===== hw/dcp_regs.svh
// Register offsets, field positions and reset values of the DMA cell channel
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH

// Register byte offsets
`define DCP_OFF_CELL_SIZE     8'h00
`define DCP_OFF_CELL_PROGRESS 8'h04
`define DCP_OFF_MATCH_PATTERN 8'h08
`define DCP_OFF_CONTROL       8'h0c
`define DCP_OFF_STATUS        8'h10

// Control fields
`define DCP_CTRL_ENABLE_BIT   0
`define DCP_CTRL_PTERM_BIT    1

// Status fields
`define DCP_STAT_BUSY_BIT     0
`define DCP_STAT_DONE_BIT     1
`define DCP_STAT_HIT_BIT      2
`define DCP_STAT_OVR_BIT      3
`define DCP_STAT_STICKY_LO    1
`define DCP_STAT_STICKY_HI    3

// Reset values
`define DCP_RST_CELL_SIZE     16'h0000
`define DCP_RST_PROGRESS      16'h0000
`define DCP_RST_PATTERN       8'h00

// Cell length used when the size field holds zero
`define DCP_CELL_LEN_ZERO     17'h10000

// Default buffer depth
`define DCP_FIFO_DEPTH        32

`endif

// ===== hw/dcp_pkg.sv
// Types shared by the DMA cell channel modules
package dcp_pkg;

	// Channel sequencer states
	typedef enum logic [0:0] {
		DCP_IDLE = 1'b0,
		DCP_MOVE = 1'b1
	} dcp_state_t;

	// Complete state of the channel
	typedef struct packed {
		dcp_state_t  state;
		logic [15:0] cellSize;
		logic [7:0]  pattern;
		logic        enable;
		logic        patTerm;
		logic [15:0] progress;
		logic [16:0] cellLen;
		logic        doneFlag;
		logic        hitFlag;
		logic        ovrFlag;
		logic        doneP;
		logic        hitP;
		logic [31:0] rdData;
	} dcp_chan_t;

endpackage : dcp_pkg

// ===== hw/dcp_pattern_cmp.sv
// Pattern byte comparator for the terminate-on-match mode
`timescale 1ns/100ps

module dcp_pattern_cmp (
	// Mode and data
	input  wire logic       termMode,
	input  wire logic       byteValid,
	input  wire logic [7:0] byteData,
	input  wire logic [7:0] patternByte,
	// Result
	output logic            hit
);

	// Only a moved byte in terminate mode can match; otherwise the pattern is inert
	assign hit = termMode & byteValid & (byteData == patternByte);

endmodule : dcp_pattern_cmp

// ===== hw/dcp_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps

module dcp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Filling side
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	// Draining side
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);

	localparam int AW = $clog2(DEPTH);

	// Depth must be a power of two so the wrapped pointers stay honest
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gBadParam
		$error("dcp_fifo: DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} dcp_fifo_ptr_t;

	dcp_fifo_ptr_t          ptr_reg;
	dcp_fifo_ptr_t          ptr_next;
	logic [WIDTH-1:0]       mem [DEPTH];
	logic                   empty;
	logic                   full;

	// Extra pointer bit tells full from empty
	assign empty    = (ptr_reg.wr == ptr_reg.rd);
	assign full     = (ptr_reg.wr[AW] != ptr_reg.rd[AW]) &&
	                  (ptr_reg.wr[AW-1:0] == ptr_reg.rd[AW-1:0]);
	assign inReady  = ~full;
	assign outValid = ~empty;
	assign outData  = mem[ptr_reg.rd[AW-1:0]];

	// Pointer advance
	always_comb begin
		ptr_next = ptr_reg;
		if (inValid && !full) begin
			ptr_next.wr = ptr_reg.wr + 1'b1;
		end
		if (outReady && !empty) begin
			ptr_next.rd = ptr_reg.rd + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

	// Storage needs no reset; empty flag hides stale words
	always_ff @(posedge clock) begin
		if (inValid && !full) begin
			mem[ptr_reg.wr[AW-1:0]] <= inData;
		end
	end

endmodule : dcp_fifo

// ===== verification/dcp_channel_asserts.sv
// Port-level checker of the DMA cell channel
`timescale 1ns/100ps

module dcp_channel_asserts #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	// Register port
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              rdStrobe,
	input wire logic [31:0]       rdData,
	// Stream and status
	input wire logic              srcValid,
	input wire logic              srcReady,
	input wire logic              busy,
	input wire logic              cellDone,
	input wire logic              patternEnd
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Read data only in the cycle after a read strobe
	a_rd_idle_zero: assert property (!$past(rdStrobe) |-> rdData == 32'h0)
		else $error("read data not zero outside read cycle");
	a_size_hi_zero: assert property ($past(rdStrobe && (addr == 'h0 || addr == 'h4))
		|-> rdData[31:16] == 16'h0) else $error("size or progress upper bits set");
	a_pat_hi_zero: assert property ($past(rdStrobe && addr == 'h8)
		|-> rdData[31:8] == 24'h0) else $error("pattern upper bits set");
	// Bytes are only taken while a cell is in flight
	a_ready_busy: assert property (srcReady |-> busy)
		else $error("byte taken while idle");
	a_done_cause: assert property (cellDone |-> !busy && $past(srcValid && srcReady))
		else $error("cell done without a last byte");
	a_done_pulse: assert property (cellDone |=> !cellDone)
		else $error("cell done longer than one cycle");
	a_end_cause: assert property (patternEnd |-> !busy && !cellDone && $past(srcReady))
		else $error("pattern end without a matching byte");
	a_end_pulse: assert property (patternEnd |=> !patternEnd && !cellDone)
		else $error("pattern end repeated");

	// Main scenarios reached
	c_cell_done: cover property (cellDone);
	c_pat_end: cover property (patternEnd);
	c_prog_read: cover property (rdStrobe && addr == 'h4 && busy);
endmodule : dcp_channel_asserts

bind dcp_channel dcp_channel_asserts #(.ADDR_W(ADDR_W)) i_chk (.clock, .rst_n, .addr,
	.rdStrobe, .rdData, .srcValid, .srcReady, .busy, .cellDone, .patternEnd);

// ===== verification/dcp_stream_model.sv
// Source and sink model on the channel's byte streams
`timescale 1ns/100ps

module dcp_stream_model (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Source side
	input wire logic        srcReady,
	output logic            srcValid,
	output logic [7:0]      srcData,
	// Sink side
	input wire logic        dstValid,
	input wire logic [7:0]  dstData,
	input wire logic        stall,
	output logic            dstReady,
	// Beat counters
	output int              sent,
	output int              got,
	output int              bad
);
	// Source offers the next value of a counting sequence whenever reset is released
	assign srcValid = rst_n;
	assign srcData  = sent[7:0];
	// Sink stalls on request so the buffer can fill
	assign dstReady = !stall;

	// Count beats; the sink sees bytes in the order they were sent
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sent <= 0;
			got  <= 0;
			bad  <= 0;
		end else begin
			if (srcValid && srcReady)
				sent <= sent + 1;
			if (dstValid && dstReady) begin
				got <= got + 1;
				if (dstData !== got[7:0])
					bad <= bad + 1;
			end
		end
	end
endmodule : dcp_stream_model

// ===== verification/test_dcp_channel.sv
// Self-checking testbench of the DMA cell channel
`timescale 1ns/100ps

module test_dcp_channel;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wrData = 32'h0;
	logic        wrStrobe = 1'b0;
	logic        rdStrobe = 1'b0;
	logic        startEvent = 1'b0;
	logic        stall = 1'b0;
	logic [31:0] rdData;
	logic        srcValid, srcReady, dstValid, dstReady, busy, cellDone, patternEnd;
	logic [7:0]  srcData, dstData;
	int          sent, got, bad, b;
	int          err_count = 0;
	int          comparisons = 0;

	// 40 MHz clock
	always #12.5 clock = ~clock;

	dcp_channel i_dut (.clock, .rst_n, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
		.startEvent, .srcValid, .srcData, .srcReady, .dstValid, .dstData, .dstReady,
		.busy, .cellDone, .patternEnd);
	dcp_stream_model i_mod (.clock, .rst_n, .srcReady, .srcValid, .srcData, .dstValid,
		.dstData, .stall, .dstReady, .sent, .got, .bad);

	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("Error t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// One-cycle strobes, a spare edge after each so strobes never collide
	task wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
		@(posedge clock);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		#1 chk(rdData, e);
		@(posedge clock);
	endtask : rd

	task go;
		b = sent;
		startEvent <= 1'b1;
		@(posedge clock);
		startEvent <= 1'b0;
	endtask : go

	// Wait for a done or pattern pulse, bounded
	task waitp(input bit p, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clock);
			#1;
			if (p ? patternEnd : cellDone)
				break;
		end
		chk(busy, 1'b0);
		chk(p ? cellDone : patternEnd, 1'b0);
		@(posedge clock);
		if (i == n) begin
			err_count++;
			final_report();
		end
	endtask : waitp

	task final_report;
		$display("Comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		// Reset values, unmapped place, widths and read-only progress
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h1c, 32'h0);
		wr(8'h00, 32'hffffffff);
		rd(8'h00, 32'h0000ffff);
		wr(8'h08, 32'h123456a5);
		rd(8'h08, 32'h000000a5);
		wr(8'h04, 32'h0000ffff);
		rd(8'h04, 32'h0);
		// Stalled sink: buffer fills, progress stops at its depth
		stall <= 1'b1;
		wr(8'h00, 32'd40);
		wr(8'h0c, 32'h1);
		go();
		repeat (60) @(posedge clock);
		rd(8'h04, 32'd32);
		stall <= 1'b0;
		waitp(1'b0, 200);
		chk(sent - b, 32'd40);
		rd(8'h04, 32'h0);
		// Size zero moves a full 65,536 bytes
		wr(8'h00, 32'h0);
		go();
		waitp(1'b0, 70000);
		chk(sent - b, 32'h10000);
		// Terminate on match at the sixth byte
		wr(8'h00, 32'd100);
		wr(8'h08, 32'((sent + 5) & 'hff));
		wr(8'h0c, 32'h3);
		go();
		waitp(1'b1, 200);
		chk(sent - b, 32'd6);
		rd(8'h04, 32'h0);
		// Pattern ignored outside terminate mode
		wr(8'h00, 32'd6);
		wr(8'h08, 32'((sent + 2) & 'hff));
		wr(8'h0c, 32'h1);
		go();
		waitp(1'b0, 200);
		chk(sent - b, 32'd6);
		// Sticky status: done and hit stay until written with ones
		rd(8'h10, 32'h6);
		wr(8'h10, 32'hf);
		rd(8'h10, 32'h0);
		// An event during a cell is refused and flagged as an overrun
		go();
		@(posedge clock);
		startEvent <= 1'b1;
		@(posedge clock);
		startEvent <= 1'b0;
		waitp(1'b0, 200);
		chk(sent - b, 32'd6);
		rd(8'h10, 32'ha);
		rd(8'h0c, 32'h1);
		repeat (40) @(posedge clock);
		chk(got, sent);
		chk(bad, 32'h0);
		final_report();
	end
endmodule : test_dcp_channel
